// File: src/dpcfg_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Link loop tuning is shadowed; writing 1 to clock-control bit 13 applies it.
// - DP dividers and tuning shadowed; writing 1 to clock-control bit 14 applies.
// - All monitor source selects reset to 0; 0 abutment, 1 local.
// - Reference divider bits 9:8 code n means divide n+1; DP resets to 01.
// - Feedback divider bits 7:0 ratio is value plus two; resets 2B.
// - Common period count bits 23:16 resets 07; do not change mid count.
// - Override bit 1 masks the engine PLL enable from switching the PLL.
// - Solution select 0 uses hard-coded dividers by rate select, else registers.
module dpcfg_regs
    import dpcfg_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port.
    input  wire logic [19:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // Clock-control register write strobe and data.
    input  wire logic        clock_control_reg_wr,
    input  wire logic [31:0] clock_control_reg_wdata,
    // Display engine and rate inputs from pins.
    input  wire logic        engine_pll_enable,
    input  wire logic        low_rate_select,
    // Link PLL outputs.
    output logic      [4:0]  link_monitor_port_select,
    output logic             link_monitor_source_sel_hi,
    output logic             link_monitor_source_sel_lo,
    output logic             link_monitor_bias_on,
    output logic      [26:0] link_loop_tuning,
    // DisplayPort PLL outputs.
    output logic      [4:0]  dp_monitor_port_select,
    output logic             dp_monitor_source_sel_hi,
    output logic             dp_monitor_source_sel_lo,
    output logic             dp_monitor_bias_on,
    output logic      [26:0] dp_loop_tuning,
    output logic             link_calibration_term,
    output logic      [2:0]  dp_spare,
    output logic      [7:0]  common_period_count,
    output logic             vco_halving,
    output logic      [1:0]  reference_divider,
    output logic      [7:0]  feedback_divider,
    output logic             dp_pll_enable
);
    import dpcfg_pkg::*;

    logic [31:0] lmon_ff;
    logic [31:0] dmon_ff;
    logic [31:0] ltune_stg;
    logic [31:0] ltune_act;
    logic [31:0] ddiv_stg;
    logic [31:0] ddiv_act;
    logic [31:0] dtune_stg;
    logic [31:0] dtune_act;
    logic [31:0] dmon_act;
    logic [31:0] dmon_stg_sel;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        eng_meta_ff;
    logic        eng_sync_ff;
    logic        rate_meta_ff;
    logic        rate_sync_ff;
    logic        pll_en_ff;
    logic        nxt_pll_en;

    // Address decode.
    wire sel_lmon  = (reg_addr == DPCFG_OFS_LINK_MON);
    wire sel_ltune = (reg_addr == DPCFG_OFS_LINK_TUNE);
    wire sel_ddiv  = (reg_addr == DPCFG_OFS_DP_DIV);
    wire sel_dmon  = (reg_addr == DPCFG_OFS_DP_MON);
    wire sel_dtune = (reg_addr == DPCFG_OFS_DP_TUNE);

    // Frequency-change requests are one-cycle strobes from clock-control writes.
    wire link_apply = clock_control_reg_wr & clock_control_reg_wdata[DPCFG_BIT_LINK_FCR];
    wire dp_apply   = clock_control_reg_wr & clock_control_reg_wdata[DPCFG_BIT_DP_FCR];

    // Link tuning copy, applied by the link frequency-change request.
    dpcfg_shadow #(
        .RST_VAL (DPCFG_RST_LINK_TUNE),
        .MASK    (DPCFG_MASK_LINK_TUNE)
    ) u_ltune (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (reg_wr & sel_ltune),
        .wr_data (reg_wdata),
        .apply   (link_apply),
        .staged  (ltune_stg),
        .active  (ltune_act)
    );

    // DP divider copy.
    dpcfg_shadow #(
        .RST_VAL (DPCFG_RST_DP_DIV),
        .MASK    (DPCFG_MASK_DP_DIV)
    ) u_ddiv (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (reg_wr & sel_ddiv),
        .wr_data (reg_wdata),
        .apply   (dp_apply),
        .staged  (ddiv_stg),
        .active  (ddiv_act)
    );

    // DP tuning copy.
    dpcfg_shadow #(
        .RST_VAL (DPCFG_RST_DP_TUNE),
        .MASK    (DPCFG_MASK_DP_TUNE)
    ) u_dtune (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (reg_wr & sel_dtune),
        .wr_data (reg_wdata),
        .apply   (dp_apply),
        .staged  (dtune_stg),
        .active  (dtune_act)
    );

    // The solution-select bit is itself double buffered on the DP request.
    dpcfg_shadow #(
        .RST_VAL (DPCFG_RST_DP_MON),
        .MASK    (32'h00000001)
    ) u_dsol (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (reg_wr & sel_dmon),
        .wr_data (reg_wdata),
        .apply   (dp_apply),
        .staged  (dmon_stg_sel),
        .active  (dmon_act)
    );

    // Monitor fields take effect on write; only the solution-select bit is shadowed.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            lmon_ff <= DPCFG_RST_LINK_MON;
            dmon_ff <= DPCFG_RST_DP_MON;
        end
        else
        begin
            if (reg_wr && sel_lmon)
                lmon_ff <= reg_wdata & DPCFG_MASK_LINK_MON;
            if (reg_wr && sel_dmon)
                dmon_ff <= reg_wdata & DPCFG_MASK_DP_MON;
        end
    end

    // Pins cross two flops before use; the first flop feeds only the second.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            eng_meta_ff  <= 1'b0;
            eng_sync_ff  <= 1'b0;
            rate_meta_ff <= 1'b0;
            rate_sync_ff <= 1'b0;
        end
        else
        begin
            eng_meta_ff  <= engine_pll_enable;
            eng_sync_ff  <= eng_meta_ff;
            rate_meta_ff <= low_rate_select;
            rate_sync_ff <= rate_meta_ff;
        end
    end

    // While masked the PLL enable holds its last state instead of following.
    assign nxt_pll_en = dmon_ff[DPCFG_POS_HW_MASK] ? pll_en_ff : eng_sync_ff;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pll_en_ff <= 1'b0;
        else
            pll_en_ff <= nxt_pll_en;
    end
    assign dp_pll_enable = pll_en_ff;

    // Solution select: 0 takes the fixed table by rate, 1 the programmed fields.
    wire use_regs = dmon_act[DPCFG_POS_FIXED_SOL];
    assign feedback_divider  = use_regs ? ddiv_act[DPCFG_POS_FB_DIV +: 8]
                             : (rate_sync_ff ? DPCFG_FIX_FB_LO : DPCFG_FIX_FB_HI);
    assign reference_divider = use_regs ? ddiv_act[DPCFG_POS_REF_DIV +: 2]
                             : (rate_sync_ff ? DPCFG_FIX_REF_LO : DPCFG_FIX_REF_HI);
    assign vco_halving       = use_regs ? ddiv_act[DPCFG_POS_VCO_HALF]
                             : (rate_sync_ff ? DPCFG_FIX_VCO_LO : DPCFG_FIX_VCO_HI);

    // Remaining divider fields pass straight from the live copy.
    assign common_period_count   = ddiv_act[DPCFG_POS_COM_CNT +: 8];
    assign link_calibration_term = ddiv_act[DPCFG_POS_LINK_CAL];
    assign dp_spare              = ddiv_act[DPCFG_POS_SPARE +: 3];
    assign dp_loop_tuning        = dtune_act[26:0];
    assign link_loop_tuning      = ltune_act[26:0];

    // Monitor fields.
    assign link_monitor_port_select   = lmon_ff[DPCFG_POS_LMON_PORT +: 5];
    assign link_monitor_source_sel_hi = lmon_ff[DPCFG_POS_LMON_HI];
    assign link_monitor_source_sel_lo = lmon_ff[DPCFG_POS_LMON_LO];
    assign link_monitor_bias_on       = lmon_ff[DPCFG_POS_LMON_BIAS];
    assign dp_monitor_port_select     = dmon_ff[DPCFG_POS_DMON_PORT +: 5];
    assign dp_monitor_source_sel_hi   = dmon_ff[DPCFG_POS_DMON_HI];
    assign dp_monitor_source_sel_lo   = dmon_ff[DPCFG_POS_DMON_LO];
    assign dp_monitor_bias_on         = dmon_ff[DPCFG_POS_DMON_BIAS];

    // Reads return what software wrote; unmapped addresses read zero.
    assign nxt_rdata = !reg_rd   ? rdata_ff
                     : sel_lmon  ? lmon_ff
                     : sel_ltune ? ltune_stg
                     : sel_ddiv  ? ddiv_stg
                     : sel_dmon  ? ((dmon_ff & ~32'h00000001) | dmon_stg_sel)
                     : sel_dtune ? dtune_stg
                     : 32'h00000000;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rdata_ff <= 32'h00000000;
        else
            rdata_ff <= nxt_rdata;
    end
    assign reg_rdata = rdata_ff;

endmodule : dpcfg_regs
`default_nettype wire

// File: pkg/dpcfg_pkg.sv
package dpcfg_pkg;

    // Register byte offsets within the display clock control space.
    localparam logic [19:0] DPCFG_OFS_LINK_MON  = 20'h46004;
    localparam logic [19:0] DPCFG_OFS_LINK_TUNE = 20'h46008;
    localparam logic [19:0] DPCFG_OFS_DP_DIV    = 20'h4600C;
    localparam logic [19:0] DPCFG_OFS_DP_MON    = 20'h46010;
    localparam logic [19:0] DPCFG_OFS_DP_TUNE   = 20'h46014;

    // Writable-bit masks; every other bit is reserved and reads zero.
    localparam logic [31:0] DPCFG_MASK_LINK_MON  = 32'h00001F07;
    localparam logic [31:0] DPCFG_MASK_LINK_TUNE = 32'h07FFFFFF;
    localparam logic [31:0] DPCFG_MASK_DP_DIV    = 32'h0FFF83FF;
    localparam logic [31:0] DPCFG_MASK_DP_MON    = 32'h1F070003;
    localparam logic [31:0] DPCFG_MASK_DP_TUNE   = 32'h07FFFFFF;

    // Reset values.
    localparam logic [31:0] DPCFG_RST_LINK_MON  = 32'h00000000;
    localparam logic [31:0] DPCFG_RST_LINK_TUNE = 32'h00000000;
    localparam logic [31:0] DPCFG_RST_DP_DIV    = 32'h0007012B;
    localparam logic [31:0] DPCFG_RST_DP_MON    = 32'h00000000;
    localparam logic [31:0] DPCFG_RST_DP_TUNE   = 32'h00000000;

    // Frequency-change request bits in the clock-control register.
    localparam int DPCFG_BIT_LINK_FCR = 13;
    localparam int DPCFG_BIT_DP_FCR   = 14;

    // Field positions of the divider register.
    localparam int DPCFG_POS_LINK_CAL  = 27;
    localparam int DPCFG_POS_SPARE     = 24;
    localparam int DPCFG_POS_COM_CNT   = 16;
    localparam int DPCFG_POS_VCO_HALF  = 15;
    localparam int DPCFG_POS_REF_DIV   = 8;
    localparam int DPCFG_POS_FB_DIV    = 0;

    // Field positions of the monitor registers.
    localparam int DPCFG_POS_LMON_PORT = 8;
    localparam int DPCFG_POS_LMON_HI   = 2;
    localparam int DPCFG_POS_LMON_LO   = 1;
    localparam int DPCFG_POS_LMON_BIAS = 0;
    localparam int DPCFG_POS_DMON_PORT = 24;
    localparam int DPCFG_POS_DMON_HI   = 18;
    localparam int DPCFG_POS_DMON_LO   = 17;
    localparam int DPCFG_POS_DMON_BIAS = 16;
    localparam int DPCFG_POS_HW_MASK   = 1;
    localparam int DPCFG_POS_FIXED_SOL = 0;

    // Hard-coded divider solutions chosen by the low-rate select input.
    localparam logic [7:0] DPCFG_FIX_FB_HI   = 8'h2B;
    localparam logic [1:0] DPCFG_FIX_REF_HI  = 2'h1;
    localparam logic       DPCFG_FIX_VCO_HI  = 1'b0;
    localparam logic [7:0] DPCFG_FIX_FB_LO   = 8'h2B;
    localparam logic [1:0] DPCFG_FIX_REF_LO  = 2'h1;
    localparam logic       DPCFG_FIX_VCO_LO  = 1'b1;

endpackage : dpcfg_pkg

// File: src/dpcfg_shadow.sv
`timescale 1ns/1ns
`default_nettype none
module dpcfg_shadow #(
    parameter logic [31:0] RST_VAL = 32'h00000000,
    parameter logic [31:0] MASK    = 32'hFFFFFFFF
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Software side.
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic        apply,
    // Register contents.
    output logic      [31:0] staged,
    output logic      [31:0] active
);
    logic [31:0] staged_ff;
    logic [31:0] active_ff;
    logic [31:0] nxt_staged;
    logic [31:0] nxt_active;

    // A write in the apply cycle goes live at once, so the two never race.
    assign nxt_staged = wr_en ? (wr_data & MASK) : staged_ff;
    assign nxt_active = apply ? nxt_staged : active_ff;
    assign staged     = staged_ff;
    assign active     = active_ff;

    // Both copies start at the documented reset value.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            staged_ff <= RST_VAL;
            active_ff <= RST_VAL;
        end
        else
        begin
            staged_ff <= nxt_staged;
            active_ff <= nxt_active;
        end
    end
endmodule : dpcfg_shadow
`default_nettype wire

// File: tb/dpcfg_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Pin-level checks; the staged copies are hidden, so each check ties a live output or read data to a write, apply or read.
module dpcfg_regs_properties
    import dpcfg_pkg::*;
(
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register port.
    input wire logic [19:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Apply strobe.
    input wire logic        clock_control_reg_wr,
    input wire logic [31:0] clock_control_reg_wdata,
    // Live outputs.
    input wire logic        link_monitor_source_sel_hi,
    input wire logic        link_monitor_source_sel_lo,
    input wire logic [26:0] link_loop_tuning,
    input wire logic [26:0] dp_loop_tuning,
    input wire logic [7:0]  common_period_count
);
    // Apply requests and the address map, decoded once for all properties.
    wire link_go = clock_control_reg_wr && clock_control_reg_wdata[DPCFG_BIT_LINK_FCR];
    wire dp_go   = clock_control_reg_wr && clock_control_reg_wdata[DPCFG_BIT_DP_FCR];
    wire mapped  = reg_addr inside {DPCFG_OFS_LINK_MON, DPCFG_OFS_LINK_TUNE, DPCFG_OFS_DP_DIV,
                                    DPCFG_OFS_DP_MON, DPCFG_OFS_DP_TUNE};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // A staged write immediately followed by its apply strobe.
    sequence s_link_stage;
        reg_wr && reg_addr == DPCFG_OFS_LINK_TUNE ##1 link_go && !reg_wr;
    endsequence
    sequence s_dp_stage;
        reg_wr && reg_addr == DPCFG_OFS_DP_TUNE ##1 dp_go && !reg_wr;
    endsequence
    a_link_tune_held: assert property (!link_go |=> $stable(link_loop_tuning))
        else $error("link tuning moved without apply");
    a_count_held: assert property (!dp_go |=> $stable(common_period_count))
        else $error("common period count moved without apply");
    a_link_tune_apply: assert property (s_link_stage |=> link_loop_tuning == $past(reg_wdata[26:0], 2))
        else $error("link tuning not applied");
    a_dp_tune_apply: assert property (s_dp_stage |=> dp_loop_tuning == $past(reg_wdata[26:0], 2))
        else $error("dp tuning not applied");
    a_mon_sel_write: assert property (reg_wr && reg_addr == DPCFG_OFS_LINK_MON |=>
        {link_monitor_source_sel_hi, link_monitor_source_sel_lo} == $past(reg_wdata[2:1]))
        else $error("monitor select not taken");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (reg_rd && reg_addr == DPCFG_OFS_DP_MON |=>
        (reg_rdata & ~DPCFG_MASK_DP_MON) == 32'h0)
        else $error("reserved bits read nonzero");
    a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule : dpcfg_regs_properties
bind dpcfg_regs dpcfg_regs_properties i_props (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clock_control_reg_wr(clock_control_reg_wr),
    .clock_control_reg_wdata(clock_control_reg_wdata), .link_loop_tuning(link_loop_tuning),
    .link_monitor_source_sel_hi(link_monitor_source_sel_hi), .dp_loop_tuning(dp_loop_tuning),
    .link_monitor_source_sel_lo(link_monitor_source_sel_lo),
    .common_period_count(common_period_count)
);
`default_nettype wire

// File: tb/display_pll_config_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module display_pll_config_regs_test;
    import dpcfg_pkg::*;
    logic        clk_sys, rst, reg_wr, reg_rd, clock_control_reg_wr;
    logic        engine_pll_enable, low_rate_select, link_calibration_term;
    logic        link_monitor_source_sel_hi, link_monitor_source_sel_lo, link_monitor_bias_on;
    logic        dp_monitor_source_sel_hi, dp_monitor_source_sel_lo, dp_monitor_bias_on;
    logic        vco_halving, dp_pll_enable;
    logic [19:0] reg_addr;
    logic [31:0] reg_wdata, clock_control_reg_wdata, reg_rdata;
    logic [4:0]  link_monitor_port_select, dp_monitor_port_select;
    logic [26:0] link_loop_tuning, dp_loop_tuning;
    logic [7:0]  common_period_count, feedback_divider;
    logic [2:0]  dp_spare;
    logic [1:0]  reference_divider;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    localparam logic [19:0] ADR [5] = '{DPCFG_OFS_LINK_MON, DPCFG_OFS_LINK_TUNE,
        DPCFG_OFS_DP_DIV, DPCFG_OFS_DP_MON, DPCFG_OFS_DP_TUNE};
    localparam logic [31:0] MSK [5] = '{DPCFG_MASK_LINK_MON, DPCFG_MASK_LINK_TUNE,
        DPCFG_MASK_DP_DIV, DPCFG_MASK_DP_MON, DPCFG_MASK_DP_TUNE};
    localparam logic [31:0] RST [5] = '{DPCFG_RST_LINK_MON, DPCFG_RST_LINK_TUNE,
        DPCFG_RST_DP_DIV, DPCFG_RST_DP_MON, DPCFG_RST_DP_TUNE};

    dpcfg_regs i_dut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .clock_control_reg_wr, .clock_control_reg_wdata, .engine_pll_enable, .low_rate_select,
        .link_monitor_port_select, .link_monitor_source_sel_hi, .link_monitor_source_sel_lo,
        .link_monitor_bias_on, .link_loop_tuning, .dp_monitor_port_select,
        .dp_monitor_source_sel_hi, .dp_monitor_source_sel_lo, .dp_monitor_bias_on,
        .dp_loop_tuning, .link_calibration_term, .dp_spare, .common_period_count,
        .vco_halving, .reference_divider, .feedback_divider, .dp_pll_enable);

    // All eight monitor output fields packed for one compare.
    wire [15:0] mon_pins = {link_monitor_port_select, link_monitor_source_sel_hi,
        link_monitor_source_sel_lo, link_monitor_bias_on, dp_monitor_port_select,
        dp_monitor_source_sel_hi, dp_monitor_source_sel_lo, dp_monitor_bias_on};

    // Free-running 100 MHz clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Bus tasks idle one cycle first, so a strobe is never lowered and raised in one step.
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string name);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(name, exp, reg_rdata);
    endtask : rd

    // Apply starts at once, so it lands on the cycle right after a staging write.
    task automatic go(input logic [31:0] bits);
        clock_control_reg_wdata = bits;
        clock_control_reg_wr = 1'b1;
        @(negedge clk_sys);
        clock_control_reg_wr = 1'b0;
    endtask : go

    task automatic t_reset();
        for (int i = 0; i < 5; i++) rd(ADR[i], RST[i], "reset value");
        chk("fixed dividers", {21'h0, DPCFG_FIX_VCO_HI, DPCFG_FIX_REF_HI, DPCFG_FIX_FB_HI},
            {21'h0, vco_halving, reference_divider, feedback_divider});
        chk("monitor pins reset", 32'h0, {16'h0, mon_pins});
        $display("t_reset done");
    endtask : t_reset

    task automatic t_reserved();
        for (int i = 0; i < 5; i++)
        begin
            wr(ADR[i], 32'hFFFFFFFF);
            rd(ADR[i], MSK[i], "masked readback");
        end
        chk("monitor local", 32'h3, {30'h0, link_monitor_source_sel_hi,
            link_monitor_source_sel_lo});
        chk("monitor pins set", 32'hFFFF, {16'h0, mon_pins});
        wr(20'h46018, 32'hFFFFFFFF);
        rd(20'h46018, 32'h0, "unmapped read");
        wr(DPCFG_OFS_LINK_MON, 32'h0);
        chk("monitor abutment", 32'h0, {30'h0, link_monitor_source_sel_hi,
            link_monitor_source_sel_lo});
        chk("monitor pins link cleared", 32'h00FF, {16'h0, mon_pins});
        $display("t_reserved done");
    endtask : t_reserved

    task automatic t_link();
        wr(DPCFG_OFS_LINK_TUNE, 32'h05A5A5A5);
        go(32'h00004000);
        chk("link tuning staged", 32'h0, {5'h0, link_loop_tuning});
        wr(DPCFG_OFS_LINK_TUNE, 32'h0253C00F);
        go(32'h00002000);
        chk("link tuning live", 32'h0253C00F, {5'h0, link_loop_tuning});
        $display("t_link done");
    endtask : t_link

    task automatic t_dp();
        wr(DPCFG_OFS_DP_MON, 32'h1);
        wr(DPCFG_OFS_DP_DIV, 32'h0A1A8234);
        wr(DPCFG_OFS_DP_TUNE, 32'h06000F0F);
        chk("feedback staged", 32'hFF, {24'h0, feedback_divider});
        go(32'h00004000);
        chk("divider fields", 32'h0A1A8234, {4'h0, link_calibration_term, dp_spare,
            common_period_count, vco_halving, 5'h0, reference_divider,
            feedback_divider});
        chk("dp tuning live", 32'h06000F0F, {5'h0, dp_loop_tuning});
        $display("t_dp done");
    endtask : t_dp

    task automatic t_fixed();
        wr(DPCFG_OFS_DP_MON, 32'h0);
        go(32'h00004000);
        low_rate_select = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("fixed low rate", {21'h0, DPCFG_FIX_VCO_LO, DPCFG_FIX_REF_LO, DPCFG_FIX_FB_LO},
            {21'h0, vco_halving, reference_divider, feedback_divider});
        low_rate_select = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("fixed high rate", {21'h0, DPCFG_FIX_VCO_HI, DPCFG_FIX_REF_HI, DPCFG_FIX_FB_HI},
            {21'h0, vco_halving, reference_divider, feedback_divider});
        $display("t_fixed done");
    endtask : t_fixed

    task automatic t_mask();
        engine_pll_enable = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("pll enable follows", 32'h1, {31'h0, dp_pll_enable});
        wr(DPCFG_OFS_DP_MON, 32'h2);
        engine_pll_enable = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("pll enable masked", 32'h1, {31'h0, dp_pll_enable});
        wr(DPCFG_OFS_DP_MON, 32'h0);
        repeat (4) @(negedge clk_sys);
        chk("pll enable released", 32'h0, {31'h0, dp_pll_enable});
        $display("t_mask done");
    endtask : t_mask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // Hang guard; the whole run needs under a hundred cycles.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // Main sequence.
    initial
    begin
        {rst, reg_wr, reg_rd, clock_control_reg_wr, engine_pll_enable, low_rate_select} = 6'h20;
        reg_addr = 20'h0;
        reg_wdata = 32'h0;
        clock_control_reg_wdata = 32'h0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_reserved();
        t_link();
        t_dp();
        t_fixed();
        t_mask();
        end_sim();
    end
endmodule : display_pll_config_regs_test
`default_nettype wire
